// ---- hdl/pmic_control_register_bank.sv ----
`timescale 1ns/1ps
module pmic_control_register_bank
    import pmic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR       = DEV_ADDR_RESET,
    parameter logic [1:0] PART_ID        = 2'h1,  // Arbitrary value
    parameter logic [7:0] CONFIG_VERSION = 8'h5a  // Arbitrary value
) (
    input  wire logic            SYS_CLK,
    input  wire logic            RST_N,
    input  wire logic            SCL,
    input  wire logic            SDA_IN,
    output wire logic            SDA_OUT,
    output wire logic            SDA_OE,
    input  wire logic            EN_PIN,
    input  wire logic [3:0]      POWER_GOOD_FAULTS_IN,
    input  wire logic [7:0]      TOP_STAT_IN,
    input  wire logic [7:0]      BUCK_STAT_IN,
    input  wire logic [7:0]      LINEAR_STATUS_IN,
    input  wire logic [8:0]      LOAD_CURRENT_IN,
    input  wire logic [3:0][7:0] INT_EVENT,
    output wire logic            BUCK_A_RUN,
    output wire logic            BUCK_A_FORCED_PWM,
    output wire logic            BUCK_A_DISCHARGE,
    output wire logic [7:0]      PLL_SETTING,
    output wire logic [7:0]      PGOOD_SETTING_A,
    output wire logic [7:0]      PGOOD_SETTING_B,
    output wire logic            LOAD_SELECT,
    output wire logic [3:0][7:0] INT_FLAGS,
    output wire logic [3:0][7:0] INT_MASKS
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic            scl_q;     // Previous clock sample
        logic            sda_q;     // Previous data sample
        i2c_state_type   st;        // Serial target state
        logic [3:0]      cnt;       // Bits in current byte
        logic [7:0]      shift;     // Byte shifter
        logic            rw;        // Read transfer
        logic            have_reg;  // Register byte received
        logic            nack;      // Host refused a byte
        logic [7:0]      index;     // Register index
        logic            sda_oe;    // Pulling data low
        logic [7:0]      buck_a;    // First converter control
        logic [7:0]      pll;       // Clock PLL setup
        logic [7:0]      pg_a;      // Power-good control A
        logic [7:0]      pg_b;      // Power-good control B
        logic [7:0]      load_sel;  // Load meter select
        logic [3:0][7:0] intr;      // Sticky interrupt flags
        logic [3:0][7:0] imask;     // Interrupt masks
    } bank_type;

    localparam bank_type BANK_RESET = '{scl_q: 1'b1, sda_q: 1'b1, st: ST_IDLE,
                                        buck_a: BUCK_A_RESET, default: '0};

    bank_type   r;          // Registered state
    bank_type   nxt;        // Next state
    logic [7:0] rd;         // Read data at index
    logic       wr_en;      // Data byte commit strobe
    logic       sw_reset;   // Software reset strobe
    logic       scl_rise;   // Clock rising
    logic       scl_fall;   // Clock falling
    logic       start;      // Start condition
    logic       stop;       // Stop condition

    buck_ctrl_if buck_bus ();  // Link to converter control

    // ------------------------------------------------------------
    // Line events
    // ------------------------------------------------------------
    assign scl_rise = SCL & ~r.scl_q;
    assign scl_fall = ~SCL & r.scl_q;
    assign start    = SCL & r.scl_q & r.sda_q & ~SDA_IN;
    assign stop     = SCL & r.scl_q & ~r.sda_q & SDA_IN;

    // Read multiplexer, unmapped reads zero
    function automatic logic [7:0] read_reg(input bank_type b, input logic [7:0] idx);
        case (idx)
            ADDR_DEVICE_REVISION: read_reg = {PART_ID, DEVREV_LOW};
            ADDR_CONFIG_VERSION:  read_reg = CONFIG_VERSION;
            ADDR_BUCK_A_CONTROL:  read_reg = b.buck_a;
            ADDR_PLL_CONTROL:     read_reg = b.pll;
            ADDR_PG_CONTROL_A:    read_reg = b.pg_a;
            ADDR_PG_CONTROL_B:    read_reg = b.pg_b;
            ADDR_PG_FAULTS:       read_reg = {4'h0, POWER_GOOD_FAULTS_IN} & POWER_GOOD_FAULTS_RMASK;
            ADDR_SOFTWARE_RESET:  read_reg = 8'h00;
            ADDR_TOP_INT_A:       read_reg = b.intr[0];
            ADDR_TOP_INT_B:       read_reg = b.intr[1];
            ADDR_BUCK_INT:        read_reg = b.intr[2];
            ADDR_LINEAR_INT:      read_reg = b.intr[3];
            ADDR_TOP_STATUS:      read_reg = TOP_STAT_IN & TOP_STAT_RMASK;
            ADDR_BUCK_STATUS:     read_reg = BUCK_STAT_IN & CONV_STAT_RMASK;
            ADDR_LINEAR_STATUS:   read_reg = LINEAR_STATUS_IN & CONV_STAT_RMASK;
            ADDR_TOP_MASK_A:      read_reg = b.imask[0];
            ADDR_TOP_MASK_B:      read_reg = b.imask[1];
            ADDR_BUCK_MASK:       read_reg = b.imask[2];
            ADDR_LINEAR_MASK:     read_reg = b.imask[3];
            ADDR_LOAD_SELECT:     read_reg = b.load_sel;
            ADDR_LOAD_HIGH:       read_reg = {7'h00, LOAD_CURRENT_IN[8]};
            ADDR_LOAD_LOW:        read_reg = LOAD_CURRENT_IN[7:0];
            default:              read_reg = 8'h00;
        endcase
    endfunction : read_reg

    // ------------------------------------------------------------
    // Serial target and register file
    // ------------------------------------------------------------
    always_comb begin
        nxt      = r;
        rd       = read_reg(r, r.index);
        wr_en    = 1'b0;
        sw_reset = 1'b0;
        nxt.scl_q = SCL;
        nxt.sda_q = SDA_IN;
        if (start) begin
            // Start or repeated start, index kept for reads
            nxt.st       = ST_ADDR;
            nxt.cnt      = 4'h0;
            nxt.have_reg = 1'b0;
            nxt.sda_oe   = 1'b0;
        end else if (stop) begin
            // Stop ends any transfer
            nxt.st     = ST_IDLE;
            nxt.sda_oe = 1'b0;
        end else begin
            case (r.st)
                ST_IDLE: begin
                    // Wait for start
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        nxt.shift = {r.shift[6:0], SDA_IN};
                        nxt.cnt   = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == BYTE_BITS) begin
                        // Address plus direction bit first
                        if (r.shift[7:1] == DEV_ADDR) begin
                            nxt.sda_oe = 1'b1;
                            nxt.rw     = r.shift[0];
                            nxt.st     = ST_ADDR_ACK;
                        end else begin
                            nxt.st = ST_WAIT;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        nxt.cnt = 4'h0;
                        if (r.rw) begin
                            // First read bit goes out here
                            nxt.shift  = rd;
                            nxt.sda_oe = ~rd[7];
                            nxt.nack   = 1'b0;
                            nxt.st     = ST_TX;
                        end else begin
                            nxt.sda_oe = 1'b0;
                            nxt.st     = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        nxt.shift = {r.shift[6:0], SDA_IN};
                        nxt.cnt   = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == BYTE_BITS) begin
                        nxt.sda_oe = 1'b1;
                        nxt.st     = ST_RX_ACK;
                        if (r.have_reg) begin
                            wr_en = 1'b1;
                        end else begin
                            // Second byte selects the register
                            nxt.index    = r.shift;
                            nxt.have_reg = 1'b1;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt.sda_oe = 1'b0;
                        nxt.cnt    = 4'h0;
                        nxt.st     = ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        nxt.cnt = r.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r.cnt == BYTE_BITS) begin
                            nxt.sda_oe = 1'b0;
                            nxt.st     = ST_TX_ACK;
                        end else begin
                            nxt.shift  = {r.shift[6:0], 1'b0};
                            nxt.sda_oe = ~r.shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nxt.nack = SDA_IN;
                    end else if (scl_fall) begin
                        if (r.nack) begin
                            nxt.st = ST_WAIT;
                        end else begin
                            // Same register again, index unchanged
                            nxt.shift  = rd;
                            nxt.sda_oe = ~rd[7];
                            nxt.cnt    = 4'h0;
                            nxt.st     = ST_TX;
                        end
                    end
                end
                ST_WAIT: begin
                    // Not addressed or refused, wait for stop
                end
                default: begin
                    nxt.st     = ST_IDLE;
                    nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // Register write and index step
        if (wr_en) begin
            nxt.index = r.index + 8'h01;
            case (r.index)
                ADDR_BUCK_A_CONTROL: nxt.buck_a   = r.shift & BUCK_A_WMASK;
                ADDR_PLL_CONTROL:    nxt.pll      = r.shift & PLL_WMASK;
                ADDR_PG_CONTROL_A:   nxt.pg_a     = r.shift & PG_A_WMASK;
                ADDR_PG_CONTROL_B:   nxt.pg_b     = r.shift & PG_B_WMASK;
                ADDR_SOFTWARE_RESET: sw_reset     = r.shift[SW_RESET_BIT];
                ADDR_TOP_INT_A:      nxt.intr[0]  = r.intr[0] & ~r.shift;
                ADDR_TOP_INT_B:      nxt.intr[1]  = r.intr[1] & ~r.shift;
                ADDR_BUCK_INT:       nxt.intr[2]  = r.intr[2] & ~r.shift;
                ADDR_LINEAR_INT:     nxt.intr[3]  = r.intr[3] & ~r.shift;
                ADDR_TOP_MASK_A:     nxt.imask[0] = r.shift & MASK_WMASK[0];
                ADDR_TOP_MASK_B:     nxt.imask[1] = r.shift & MASK_WMASK[1];
                ADDR_BUCK_MASK:      nxt.imask[2] = r.shift & MASK_WMASK[2];
                ADDR_LINEAR_MASK:    nxt.imask[3] = r.shift & MASK_WMASK[3];
                ADDR_LOAD_SELECT:    nxt.load_sel = r.shift & LOAD_SEL_WMASK;
                default: begin
                    // Read-only or unmapped, write dropped
                end
            endcase
        end
        // Software reset reloads defaults and flags itself
        if (sw_reset) begin
            nxt.buck_a = BUCK_A_RESET;
            nxt.pll      = 8'h00;
            nxt.pg_a     = 8'h00;
            nxt.pg_b     = 8'h00;
            nxt.load_sel = 8'h00;
            nxt.imask    = '0;
            nxt.intr     = '0;
            nxt.intr[1][RESET_INT_BIT] = 1'b1;
        end
        // Events set flags last so a set beats a clear
        for (int i = 0; i < INT_COUNT; i++) begin
            nxt.intr[i] = nxt.intr[i] | (INT_EVENT[i] & INT_WMASK[i]);
        end
    end

    // Register state
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= BANK_RESET;
        end else begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------
    // Converter control and outputs
    // ------------------------------------------------------------
    assign buck_bus.ctl    = r.buck_a[3:0];
    assign buck_bus.en_pin = EN_PIN;

    buck_a_ctrl u_buck_a (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .bus   (buck_bus)
    );

    assign SDA_OUT           = 1'b0;  // Open drain, only pulls low
    assign SDA_OE            = r.sda_oe;
    assign BUCK_A_RUN        = buck_bus.run;
    assign BUCK_A_FORCED_PWM = buck_bus.fpwm;
    assign BUCK_A_DISCHARGE  = buck_bus.discharge;
    assign PLL_SETTING       = r.pll;
    assign PGOOD_SETTING_A   = r.pg_a;
    assign PGOOD_SETTING_B   = r.pg_b;
    assign LOAD_SELECT       = r.load_sel[0];
    assign INT_FLAGS         = r.intr;
    assign INT_MASKS         = r.imask;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    addr_ack_a: assert property ((r.st == ST_ADDR && scl_fall && !start && !stop &&
        r.cnt == BYTE_BITS && r.shift[7:1] == DEV_ADDR) |=> (r.sda_oe && r.st == ST_ADDR_ACK))
        else $error("address not acknowledged");
    reg_select_a: assert property ((r.st == ST_RX && scl_fall && !start && !stop &&
        r.cnt == BYTE_BITS && !r.have_reg) |=> (r.have_reg && r.index == $past(r.shift)))
        else $error("register byte not taken as index");
    write_step_a: assert property (wr_en |=>
        r.index == 8'($past(r.index) + 8'h01))
        else $error("index did not step after write");
    read_hold_a: assert property ((r.st == ST_TX || r.st == ST_TX_ACK) |=>
        $stable(r.index))
        else $error("index moved during read");
    part_id_a: assert property ((r.st == ST_ADDR_ACK && scl_fall && r.rw && !start && !stop &&
        r.index == ADDR_DEVICE_REVISION) |=> r.shift[7:6] == PART_ID)
        else $error("part identifier wrong");
    config_code_a: assert property ((r.st == ST_ADDR_ACK && scl_fall && r.rw && !start &&
        !stop && r.index == ADDR_CONFIG_VERSION) |=> r.shift == CONFIG_VERSION)
        else $error("config version code wrong");
    buck_write_a: assert property ((wr_en && r.index == ADDR_BUCK_A_CONTROL) |=>
        r.buck_a == ($past(r.shift) & BUCK_A_WMASK))
        else $error("buck control write lost");
    event_wins_a: assert property (INT_EVENT[2][0] |=> r.intr[2][0])
        else $error("event lost against clear");

    write_seen_c: cover property (wr_en ##[1:200] wr_en);
    read_seen_c: cover property (r.st == ST_TX_ACK && scl_fall && !r.nack);
    sw_reset_c: cover property (sw_reset);
endmodule : pmic_control_register_bank

// ---- hdl/pmic_pkg.sv ----
package pmic_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_REVISION = 8'h00;
    localparam logic [7:0] ADDR_CONFIG_VERSION  = 8'h01;
    localparam logic [7:0] ADDR_BUCK_A_CONTROL  = 8'h02;
    localparam logic [7:0] ADDR_PLL_CONTROL     = 8'h14;
    localparam logic [7:0] ADDR_PG_CONTROL_A    = 8'h15;
    localparam logic [7:0] ADDR_PG_CONTROL_B    = 8'h16;
    localparam logic [7:0] ADDR_PG_FAULTS       = 8'h17;
    localparam logic [7:0] ADDR_SOFTWARE_RESET  = 8'h18;
    localparam logic [7:0] ADDR_TOP_INT_A       = 8'h19;
    localparam logic [7:0] ADDR_TOP_INT_B       = 8'h1a;
    localparam logic [7:0] ADDR_BUCK_INT        = 8'h1b;
    localparam logic [7:0] ADDR_LINEAR_INT      = 8'h1c;
    localparam logic [7:0] ADDR_TOP_STATUS      = 8'h1d;
    localparam logic [7:0] ADDR_BUCK_STATUS     = 8'h1e;
    localparam logic [7:0] ADDR_LINEAR_STATUS   = 8'h1f;
    localparam logic [7:0] ADDR_TOP_MASK_A      = 8'h20;
    localparam logic [7:0] ADDR_TOP_MASK_B      = 8'h21;
    localparam logic [7:0] ADDR_BUCK_MASK       = 8'h22;
    localparam logic [7:0] ADDR_LINEAR_MASK     = 8'h23;
    localparam logic [7:0] ADDR_LOAD_SELECT     = 8'h24;
    localparam logic [7:0] ADDR_LOAD_HIGH       = 8'h25;
    localparam logic [7:0] ADDR_LOAD_LOW        = 8'h26;
    // ------------------------------------------------------------
    // Field layouts and implemented-bit masks
    // ------------------------------------------------------------
    localparam int          FPWM_BIT        = 3;
    localparam int          RDIS_BIT        = 2;
    localparam int          PIN_GATE_BIT    = 1;
    localparam int          EN_BIT          = 0;
    localparam int          SW_RESET_BIT    = 0;
    localparam int          RESET_INT_BIT   = 0;
    localparam int          INT_COUNT       = 4;
    localparam logic [7:0]  BUCK_A_WMASK    = 8'h0f;
    localparam logic [7:0]  PLL_WMASK       = 8'h5f;
    localparam logic [7:0]  PG_A_WMASK      = 8'hff;
    localparam logic [7:0]  PG_B_WMASK      = 8'h07;
    localparam logic [7:0]  POWER_GOOD_FAULTS_RMASK  = 8'h0f;
    localparam logic [7:0]  TOP_STAT_RMASK  = 8'h9e;
    localparam logic [7:0]  CONV_STAT_RMASK = 8'hdd;
    localparam logic [7:0]  LOAD_SEL_WMASK  = 8'h01;
    // Index 0 top A, 1 top B, 2 buck, 3 linear
    localparam logic [3:0][7:0] INT_WMASK  = {8'h77, 8'h77, 8'h01, 8'hff};
    localparam logic [3:0][7:0] MASK_WMASK = {8'hdd, 8'hdd, 8'h01, 8'h95};
    // ------------------------------------------------------------
    // Reset values and serial link constants
    // ------------------------------------------------------------
    localparam logic [7:0]  BUCK_A_RESET    = 8'h07;
    localparam logic [5:0]  DEVREV_LOW      = 6'h02;
    localparam logic [6:0]  DEV_ADDR_RESET  = 7'h60;
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    // Serial target states, Gray along address, data, acknowledge
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RX       = 3'h2,
        ST_RX_ACK   = 3'h6,
        ST_TX       = 3'h7,
        ST_TX_ACK   = 3'h5,
        ST_WAIT     = 3'h4
    } i2c_state_type;
endpackage : pmic_pkg

// ---- hdl/buck_ctrl_if.sv ----
`timescale 1ns/1ps
// Control bits to the first converter and its resulting drive
interface buck_ctrl_if;
    logic [3:0] ctl;        // Low nibble of buck_a_control
    logic       en_pin;     // External enable pin level
    logic       run;        // Converter on
    logic       fpwm;       // Forced PWM mode
    logic       discharge;  // Discharge resistor connected
    modport bank (output ctl, output en_pin, input run, input fpwm, input discharge);
    modport conv (input ctl, input en_pin, output run, output fpwm, output discharge);
endinterface : buck_ctrl_if

// ---- hdl/buck_a_ctrl.sv ----
`timescale 1ns/1ps
module buck_a_ctrl
    import pmic_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    buck_ctrl_if.conv   bus
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic run;   // Converter on
        logic fpwm;  // Forced PWM
        logic dis;   // Discharge connected
    } conv_type;

    conv_type r;    // Registered state
    conv_type nxt;  // Next state

    // Decode enable, mode and discharge
    always_comb begin
        nxt      = r;
        // Pin only counts when gating is selected
        nxt.run  = bus.ctl[EN_BIT] & (~bus.ctl[PIN_GATE_BIT] | bus.en_pin);
        // Zero gives automatic PFM/PWM, one forces PWM
        nxt.fpwm = bus.ctl[FPWM_BIT];
        // Resistor only while the converter is off
        nxt.dis  = bus.ctl[RDIS_BIT] & ~nxt.run;
    end

    // Register state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign bus.run       = r.run;
    assign bus.fpwm      = r.fpwm;
    assign bus.discharge = r.dis;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    auto_mode_a: assert property (!bus.ctl[FPWM_BIT] |=> !bus.fpwm)
        else $error("auto mode not selected");
    forced_pwm_a: assert property (bus.ctl[FPWM_BIT] |=> bus.fpwm)
        else $error("forced pwm not held");
    discharge_on_a: assert property (1'b1 |=> bus.discharge ==
        ($past(bus.ctl[RDIS_BIT]) & ~bus.run))
        else $error("discharge resistor wrong");
    no_gate_a: assert property (!bus.ctl[PIN_GATE_BIT] |=>
        bus.run == $past(bus.ctl[EN_BIT]))
        else $error("run ignores register enable");
    pin_gate_a: assert property (bus.ctl[PIN_GATE_BIT] |=>
        bus.run == ($past(bus.ctl[EN_BIT]) & $past(bus.en_pin)))
        else $error("run ignores pin gating");
    off_bit_a: assert property (!bus.ctl[EN_BIT] |=> !bus.run)
        else $error("converter runs with enable clear");
    gated_on_c: cover property (bus.ctl[PIN_GATE_BIT] && bus.en_pin ##1 bus.run);
endmodule : buck_a_ctrl

// ---- tb/i2c_host_model.sv ----
`timescale 1ns/1ps
// Serial host; lines move at falling clock edges
module i2c_host_model (
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output wire logic sda_in
);
    logic drv = 1'b1;                // Host data drive, 1 = released
    initial scl = 1'b1;
    assign sda_in = drv & ~sda_oe;   // Pulled-up open-drain wire
    // Move one line, then hold it two clocks
    task automatic set(ref logic s, input logic v);
        s = v;
        repeat (2) @(negedge clk);
    endtask : set
    // Start or repeated start from either level
    task automatic start;
        set(drv, 1'b1);
        set(scl, 1'b1);
        set(drv, 1'b0);
        set(scl, 1'b0);
    endtask : start
    // Stop from a low clock
    task automatic stop;
        set(drv, 1'b0);
        set(scl, 1'b1);
        set(drv, 1'b1);
    endtask : stop
    // Nine bits MSB first; last bit is the acknowledge slot
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            set(drv, d[i]);
            set(scl, 1'b1);
            q[i] = sda_in;
            set(scl, 1'b0);
        end
    endtask : xfer
endmodule : i2c_host_model

// ---- tb/pmic_control_register_bank_tb.sv ----
`timescale 1ns/1ps
module pmic_control_register_bank_tb import pmic_pkg::*;;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       en_pin = 1'b1;
    logic        sda_oe, sda_in, scl, run, fpwm, dis, sda_out, sel;
    logic [7:0]  pll, pga, pgb;
    logic [7:0]  stat = 8'hff;   // Status inputs, all bits set
    logic [8:0]  load = 9'h1a5;  // Load meter reading
    logic [31:0] evt = 32'h0;    // Interrupt events
    logic [31:0] flags, masks;   // Sticky flags and masks seen
    int         err_total = 0;
    int         checks_done = 0;
    initial forever #4 clk = ~clk;
    // Ids are arbitrary
    pmic_control_register_bank #(.PART_ID(2'h2), .CONFIG_VERSION(8'h3c))
        pmic_control_register_bank_i (.SYS_CLK(clk), .RST_N(rst_n), .SCL(scl),
        .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .EN_PIN(en_pin),
        .POWER_GOOD_FAULTS_IN(stat[3:0]), .TOP_STAT_IN(stat), .BUCK_STAT_IN(stat), .LINEAR_STATUS_IN(stat),
        .LOAD_CURRENT_IN(load), .INT_EVENT(evt), .BUCK_A_RUN(run), .BUCK_A_FORCED_PWM(fpwm),
        .BUCK_A_DISCHARGE(dis), .PLL_SETTING(pll), .PGOOD_SETTING_A(pga),
        .PGOOD_SETTING_B(pgb), .LOAD_SELECT(sel), .INT_FLAGS(flags), .INT_MASKS(masks));
    i2c_host_model i2c_host_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in));
    // Compare and count
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Register byte then n data bytes, low byte first
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
        logic [8:0] q;
        i2c_host_model_i.start();
        i2c_host_model_i.xfer({DEV_ADDR_RESET, 2'h1}, q);
        chk("ack", {7'h0, q[0]}, 8'h00);
        i2c_host_model_i.xfer({a, 1'b1}, q);
        for (int i = 0; i < n; i++) i2c_host_model_i.xfer({d[8*i +: 8], 1'b1}, q);
        i2c_host_model_i.stop();
    endtask : wr
    // Select, then read twice in one frame
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [8:0] q;
        wr(a, 16'h0, 0);
        i2c_host_model_i.start();
        i2c_host_model_i.xfer({DEV_ADDR_RESET, 2'h3}, q);
        i2c_host_model_i.xfer({8'hff, 1'b0}, q);
        chk("read", q[8:1], exp);
        i2c_host_model_i.xfer({8'hff, 1'b1}, q);
        chk("reread", q[8:1], exp);
        i2c_host_model_i.stop();
    endtask : rd
    // Control write plus pin, then check outputs
    task automatic bk(input logic [7:0] v, input logic p, input logic [2:0] exp);
        en_pin = p;
        wr(ADDR_BUCK_A_CONTROL, {8'h0, v}, 1);
        chk("conv", {5'h0, run, fpwm, dis}, {5'h0, exp});
    endtask : bk
    // Reserved bits of writable registers stay clear
    task automatic msk;
        wr(ADDR_PG_CONTROL_B, 16'h00ff, 1);
        chk("pgood_b", pgb, 8'h07);
        wr(ADDR_TOP_MASK_A, 16'h00ff, 1);
        chk("mask", masks[7:0], 8'h95);
        wr(ADDR_LOAD_SELECT, 16'h00ff, 1);
        chk("select", {7'h0, sel}, 8'h01);
    endtask : msk
    // Event raises a sticky flag, writing one clears it
    task automatic irq;
        @(negedge clk);
        evt[16] = 1'b1;
        @(negedge clk);
        evt[16] = 1'b0;
        chk("flag", flags[23:16], 8'h01);
        rd(ADDR_BUCK_INT, 8'h01);
        wr(ADDR_BUCK_INT, 16'h0001, 1);
        chk("flag", flags[23:16], 8'h00);
    endtask : irq
    // Software reset restores defaults and raises its own flag
    task automatic swr;
        wr(ADDR_SOFTWARE_RESET, 16'h0001, 1);
        chk("pll", pll, 8'h00);
        chk("mask", masks[7:0], 8'h00);
        chk("conv", {5'h0, run, fpwm, dis}, 8'h04);
        rd(ADDR_TOP_INT_B, 8'h01);
    endtask : swr
    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("conv", {5'h0, run, fpwm, dis}, 8'h04);
        chk("sda_out", {7'h0, sda_out}, 8'h00);
        rd(ADDR_DEVICE_REVISION, 8'h82);
        rd(ADDR_CONFIG_VERSION, 8'h3c);
        rd(ADDR_BUCK_A_CONTROL, 8'h07);
        rd(ADDR_LOAD_LOW, 8'ha5);
        rd(ADDR_LOAD_HIGH, 8'h01);
        rd(ADDR_PG_FAULTS, 8'h0f);
        rd(ADDR_TOP_STATUS, 8'h9e);
        rd(ADDR_BUCK_STATUS, 8'hdd);
        wr(ADDR_PLL_CONTROL, 16'hab_ff, 2);
        chk("pll", pll, 8'h5f);
        chk("pgood", pga, 8'hab);
        bk(8'h07, 1'b0, 3'h1);
        bk(8'h09, 1'b0, 3'h6);
        bk(8'h01, 1'b1, 3'h4);
        bk(8'h04, 1'b1, 3'h1);
        bk(8'h00, 1'b1, 3'h0);
        msk();
        irq();
        swr();
        print_verdict();
    end
endmodule : pmic_control_register_bank_tb
